// ==== rtl/ssp_top.sv ====
module ssp_top
	import ssp_pkg::*;
(
	// system
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [ssp_pkg::WB_AW-1:0] adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	// serial pins (clk, sdo/sda, sdi, select)
	input  wire logic                sck_i,
	input  wire logic                sda_i,
	input  wire logic                sdi_i,
	input  wire logic                ss_n_i,
	output logic                     sck_o,
	output logic                     sck_oe_o,
	output logic                     sdo_o,
	output logic                     sdo_oe_o,
	// pins owned by serial port
	output logic                     pins_owned_o,
	output logic                     ss_owned_o,
	// port interrupt flag
	output logic                     port_irq_o
);
	import ssp_pkg::*;

	ssp_sync_if sif ();
	assign sif.raw = {sck_i, sda_i, sdi_i, ss_n_i, 1'b0};
	ssp_sync #(.W(5)) u_sync (.clk_i(clk_i), .rst_i(rst_i), .s(sif.sync_side));
	logic sck_s, sda_s, sdi_s, ss_n_s;
	assign {sck_s, sda_s, sdi_s, ss_n_s} = sif.sync[4:1];

	function automatic logic is_i2c(input logic [3:0] m);
		is_i2c = (m >= M_I2C_S7) && (m != M_SPI_NOSS);
	endfunction
	function automatic logic is_i2c_slave(input logic [3:0] m);
		is_i2c_slave = (m == M_I2C_S7) || (m == M_I2C_S10) || (m == M_I2C_S7I)
			|| (m == M_I2C_S10I);
	endfunction

	logic [7:0] ctrl_q, ctrl_d, ctrl2_q, ctrl2_d, stat_q, stat_d;
	logic [7:0] buf_q, buf_d, sr_q, sr_d, abaud_q, abaud_d, tmr_q, tmr_d;
	logic [7:0] div_q, div_d, tdiv_q, tdiv_d;
	logic [3:0] cnt_q, cnt_d;
	logic       phase_q, phase_d, irq_q, irq_d;
	logic       sck_q, sck_d, sckoe_q, sckoe_d, sdo_q, sdo_d, sdooe_q, sdooe_d;
	logic       ack_q, ack_d, tpulse_q, tpulse_d, tog_q, tog_d;
	logic       psck_q, psck_d, pss_q, psda_q;
	logic [31:0] dat_q, dat_d;
	ssp_state_t st_q, st_d;

	wire [3:0] mode   = ctrl_q[3:0];
	wire       en     = ctrl_q[CTL_EN];
	wire       clock_polarity_release    = ctrl_q[CTL_CKP];
	wire       i2c    = is_i2c(mode);
	wire       master = (mode <= M_SPI_TMR);
	wire       i2cm   = (mode == M_I2C_M) || (mode == M_I2C_FW);
	wire       req    = cyc_i && stb_i && !ack_q;
	wire       wr     = req && we_i && sel_i[0];
	wire       rd     = req && !we_i;
	wire [7:0] a8     = adr_i[9:2];
	wire       busy   = (st_q != SSP_IDLE);

	// half-bit period select
	logic [7:0] half;
	always_comb
	begin
		case (mode)
			M_SPI_D4:  half = HALF_D4;
			M_SPI_D16: half = HALF_D16;
			M_SPI_D64: half = HALF_D64;
			M_I2C_M:   half = 8'((abaud_q + 8'd1) << 1);
			default:   half = HALF_D4;
		endcase
	end

	always_comb
	begin
		ctrl_d = ctrl_q;
		ctrl2_d = ctrl2_q;
		stat_d = stat_q;
		buf_d = buf_q;
		sr_d = sr_q;
		abaud_d = abaud_q;
		tmr_d = tmr_q;
		div_d = div_q;
		tdiv_d = tdiv_q;
		cnt_d = cnt_q;
		phase_d = phase_q;
		irq_d = 1'b0;
		sck_d = sck_q;
		sdo_d = sdo_q;
		st_d = st_q;
		tpulse_d = 1'b0;
		tog_d = tog_q;
		psck_d = sck_s;
		ack_d = req;
		dat_d = 32'h0;
		// period timer: pulse every tmr_q+1 clocks, toggle halves rate
		tdiv_d = (tdiv_q == tmr_q) ? 8'h00 : 8'(tdiv_q + 8'd1);
		if (tdiv_q == tmr_q)
		begin
			tog_d = !tog_q;
			tpulse_d = tog_q;
		end
		// register writes
		if (wr)
		begin
			case (a8)
				ADDR_CTRL:  ctrl_d = dat_i[7:0];
				ADDR_STAT:  stat_d[7:6] = dat_i[7:6];
				ADDR_ABAUD: abaud_d = dat_i[7:0];
				ADDR_TIMER: tmr_d = dat_i[7:0];
				ADDR_CTRL2:
				begin
					ctrl2_d[7] = dat_i[7];
					ctrl2_d[C2_ACK_VALUE_BIT] = dat_i[C2_ACK_VALUE_BIT];
					if (!busy && i2cm && en)
						ctrl2_d[4:0] = dat_i[4:0];
				end
				ADDR_BUF:
				begin
					if (busy)
						ctrl_d[CTL_WRITE_COLLISION_FLAG] = 1'b1;
					else if (en)
					begin
						sr_d = dat_i[7:0];
						cnt_d = 4'd0;
						div_d = 8'd0;
						phase_d = 1'b0;
						if (master || (i2cm && !busy))
							st_d = SSP_SHIFT;
						sdo_d = dat_i[7];
					end
				end
				default: ;
			endcase
		end
		if (rd)
		begin
			case (a8)
				ADDR_CTRL:  dat_d = {24'h0, ctrl_q};
				ADDR_CTRL2: dat_d = {24'h0, ctrl2_q};
				ADDR_STAT:  dat_d = {24'h0, stat_q};
				ADDR_ABAUD: dat_d = {24'h0, abaud_q};
				ADDR_TIMER: dat_d = {24'h0, tmr_q};
				ADDR_IFLAG: dat_d = {28'h0, irq_q, 3'h0};
				ADDR_BUF:
				begin
					dat_d = {24'h0, buf_q};
					stat_d[ST_BF] = 1'b0;
				end
				default:    dat_d = 32'h0;
			endcase
		end
		// i2c master sequence launch
		if (st_q == SSP_IDLE && i2cm && en)
		begin
			if (ctrl2_q[C2_SEN]) st_d = SSP_START;
			else if (ctrl2_q[C2_RESTART_COND_ENABLE]) st_d = SSP_RESTART;
			else if (ctrl2_q[C2_PEN]) st_d = SSP_STOP;
			else if (ctrl2_q[C2_ACK_SEQUENCE_ENABLE]) st_d = SSP_ACK;
			else if (ctrl2_q[C2_RCEN])
			begin
				st_d = SSP_SHIFT;
				cnt_d = 4'd0;
				sr_d = 8'hff;
			end
			div_d = 8'd0;
			phase_d = 1'b0;
		end
		// bit engine
		if (busy)
		begin
			if ((mode == M_SPI_TMR) ? tpulse_q : (div_q + 8'd1 >= half))
			begin
				div_d = 8'd0;
				phase_d = !phase_q;
				if (st_q == SSP_SHIFT)
				begin
					// phase 0 leading edge, phase 1 trailing edge
					sck_d = phase_q ? clock_polarity_release : !clock_polarity_release;
					if (!phase_q && !stat_q[ST_SMP])
						sr_d = {sr_q[6:0], i2c ? sda_s : sdi_s};
					if (phase_q)
					begin
						if (stat_q[ST_SMP] && !i2c)
							sr_d = {sr_q[6:0], sdi_s};
						if (i2c && !stat_q[ST_SMP])
							sr_d = {sr_q[6:0], sda_s};
						cnt_d = 4'(cnt_q + 4'd1);
						sdo_d = sr_d[7];
						if (cnt_q == BITS - 4'd1)
						begin
							st_d = SSP_IDLE;
							buf_d = sr_d;
							irq_d = 1'b1;
							if (stat_q[ST_BF] && i2c && ctrl2_q[C2_RCEN])
								ctrl_d[CTL_OV] = 1'b1;
							stat_d[ST_BF] = 1'b1;
							ctrl2_d[C2_RCEN] = 1'b0;
							if (i2c && !ctrl2_q[C2_RCEN])
								ctrl2_d[C2_ACK_STATUS_BIT] = sda_s;
						end
					end
				end
				else
				begin
					// start, restart, stop, ack: two half-bit steps
					sck_d = phase_q;
					case (st_q)
						SSP_START:   sdo_d = 1'b0;
						SSP_RESTART: sdo_d = phase_q ? 1'b0 : 1'b1;
						SSP_STOP:    sdo_d = phase_q ? 1'b1 : 1'b0;
						SSP_ACK:     sdo_d = ctrl2_q[C2_ACK_VALUE_BIT];
						default:     sdo_d = sdo_q;
					endcase
					if (phase_q)
					begin
						st_d = SSP_IDLE;
						ctrl2_d[4:0] = 5'h0;
						irq_d = 1'b1;
					end
				end
			end
			else
				div_d = 8'(div_q + 8'd1);
		end
		// spi slave: shift on pin clock edges, framed by select in mode M_SPI_SS only
		if (en && (mode == M_SPI_SS || mode == M_SPI_NOSS))
		begin
			if (mode == M_SPI_SS && ss_n_s)
				cnt_d = 4'd0;
			else if (sck_s != psck_q)
			begin
				if ((sck_s ^ clock_polarity_release) == stat_q[ST_CKE])
					sdo_d = sr_q[7];
				else
				begin
					sr_d = {sr_q[6:0], sdi_s};
					cnt_d = 4'(cnt_q + 4'd1);
					if (cnt_q == BITS - 4'd1)
					begin
						cnt_d = 4'd0;
						buf_d = {sr_q[6:0], sdi_s};
						if (stat_q[ST_BF]) ctrl_d[CTL_OV] = 1'b1;
						stat_d[ST_BF] = 1'b1;
						irq_d = 1'b1;
					end
				end
			end
		end
		// i2c slave start/stop detection
		if (en && is_i2c_slave(mode) && sck_s && sda_s != psda_q)
		begin
			stat_d[ST_S] = !sda_s;
			stat_d[ST_P] = sda_s;
			if (mode[3]) irq_d = 1'b1;
		end
		if (!en)
		begin
			st_d = SSP_IDLE;
			cnt_d = 4'd0;
			stat_d[ST_S] = 1'b0;
			stat_d[ST_P] = 1'b0;
			sck_d = clock_polarity_release;
		end
		stat_d[ST_RW] = i2cm && (st_d != SSP_IDLE);
		// drivers: enable only when port owns the pins
		sckoe_d = en && ((master && !i2c) || (i2cm && !sck_d)
			|| (is_i2c_slave(mode) && !clock_polarity_release));
		sdooe_d = en && (i2c ? !sdo_d && (i2cm || st_q == SSP_ACK)
			: !(mode == M_SPI_SS && ss_n_s));
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= CTRL_RST;
			ctrl2_q <= CTRL2_RST;
			stat_q <= STAT_RST;
			buf_q <= 8'h00;
			sr_q <= 8'h00;
			abaud_q <= ABAUD_RST;
			tmr_q <= TIMER_RST;
			div_q <= 8'h00;
			tdiv_q <= 8'h00;
			cnt_q <= 4'h0;
			phase_q <= 1'b0;
			irq_q <= 1'b0;
			sck_q <= 1'b0;
			sckoe_q <= 1'b0;
			sdo_q <= 1'b1;
			sdooe_q <= 1'b0;
			ack_q <= 1'b0;
			tpulse_q <= 1'b0;
			tog_q <= 1'b0;
			psck_q <= 1'b0;
			pss_q <= 1'b1;
			psda_q <= 1'b1;
			dat_q <= 32'h0;
			st_q <= SSP_IDLE;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			ctrl2_q <= ctrl2_d;
			stat_q <= stat_d;
			buf_q <= buf_d;
			sr_q <= sr_d;
			abaud_q <= abaud_d;
			tmr_q <= tmr_d;
			div_q <= div_d;
			tdiv_q <= tdiv_d;
			cnt_q <= cnt_d;
			phase_q <= phase_d;
			irq_q <= irq_d || (irq_q && !(wr && a8 == ADDR_IFLAG && !dat_i[3]));
			sck_q <= sck_d;
			sckoe_q <= sckoe_d;
			sdo_q <= sdo_d;
			sdooe_q <= sdooe_d;
			ack_q <= ack_d;
			tpulse_q <= tpulse_d;
			tog_q <= tog_d;
			psck_q <= psck_d;
			pss_q <= ss_n_s;
			psda_q <= sda_s;
			dat_q <= dat_d;
			st_q <= st_d;
		end
	end

	logic own_q, ssown_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			own_q <= 1'b0;
			ssown_q <= 1'b0;
		end
		else
		begin
			own_q <= en;
			ssown_q <= en && mode == M_SPI_SS;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign sck_o = sck_q;
	assign sck_oe_o = sckoe_q;
	assign sdo_o = sdo_q;
	assign sdo_oe_o = sdooe_q;
	assign pins_owned_o = own_q;
	assign ss_owned_o = ssown_q;
	assign port_irq_o = irq_q;
endmodule

// ==== rtl/ssp_pkg.sv ====
// Notes on behaviour
// - spi master samples input at end of bit when phase bit set, middle otherwise.
// - idle-low clock: spi slave shifts data out on rising edge when edge bit set, else falling; spi master always on falling.
// - i2c byte arriving while buffer full sets overflow; ignored on transmit; software clears.
// - enable in spi takes over clock, data out and data in pins, and the select pin in mode 0100 only.
// - enable in i2c takes over bus data and clock pins.
// - enable cleared disables the port and returns pins to general i/o.
// - i2c slave holds clock low while polarity bit is 0, releases at 1.
// - modes 0000/0001/0010 are spi master at fosc/4, /16, /64.
// - mode 0011 is spi master at half the period timer output rate.
// - mode 0100 spi slave with select; 0101 slave with select pin freed.
// - modes 0110 and 0111 are i2c slave with 7 or 10 bit address.
// - mode 1000 is i2c master, bus clock fosc over 4 times (value plus one).
// - mode 1011 is firmware controlled i2c master, slave function idle.
// - modes 1110/1111 are i2c slave raising interrupt on start and stop.
// - i2c master transmit clears ack status on ack, sets it on no ack.
// - after eight bits, byte moves to buffer, buffer full and interrupt flag set.
// - buffer write during a master-mode transfer is discarded and sets write collision flag.
// - software read of the buffer clears the buffer full flag.
// - shift register moves data most significant bit first.
package ssp_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h14;
	localparam logic [7:0] ADDR_CTRL2  = 8'h91;
	localparam logic [7:0] ADDR_STAT   = 8'h94;
	localparam logic [7:0] ADDR_BUF    = 8'h13;
	localparam logic [7:0] ADDR_ABAUD  = 8'h93;
	localparam logic [7:0] ADDR_IFLAG  = 8'h0c;
	localparam logic [7:0] ADDR_TIMER  = 8'h11;
	localparam int         WB_AW       = 10;
	// control, status and control2 bit positions
	localparam int CTL_WRITE_COLLISION_FLAG = 7;
	localparam int CTL_OV   = 6;
	localparam int CTL_EN   = 5;
	localparam int CTL_CKP  = 4;
	localparam int ST_SMP   = 7;
	localparam int ST_CKE   = 6;
	localparam int ST_P     = 4;
	localparam int ST_S     = 3;
	localparam int ST_RW    = 2;
	localparam int ST_BF    = 0;
	localparam int C2_ACK_STATUS_BIT = 6;
	localparam int C2_ACK_VALUE_BIT   = 5;
	localparam int C2_ACK_SEQUENCE_ENABLE   = 4;
	localparam int C2_RCEN    = 3;
	localparam int C2_PEN     = 2;
	localparam int C2_RESTART_COND_ENABLE    = 1;
	localparam int C2_SEN     = 0;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] STAT_RST  = 8'h00;
	localparam logic [7:0] ABAUD_RST = 8'h00;
	localparam logic [7:0] TIMER_RST = 8'hff;
	localparam logic [3:0] M_SPI_D4   = 4'h0;
	localparam logic [3:0] M_SPI_D16  = 4'h1;
	localparam logic [3:0] M_SPI_D64  = 4'h2;
	localparam logic [3:0] M_SPI_TMR  = 4'h3;
	localparam logic [3:0] M_SPI_SS   = 4'h4;
	localparam logic [3:0] M_SPI_NOSS = 4'h5;
	localparam logic [3:0] M_I2C_S7   = 4'h6;
	localparam logic [3:0] M_I2C_S10  = 4'h7;
	localparam logic [3:0] M_I2C_M    = 4'h8;
	localparam logic [3:0] M_I2C_FW   = 4'hb;
	localparam logic [3:0] M_I2C_S7I  = 4'he;
	localparam logic [3:0] M_I2C_S10I = 4'hf;
	// half-bit divider counts (system clocks per half bit)
	localparam logic [7:0] HALF_D4  = 8'd2;
	localparam logic [7:0] HALF_D16 = 8'd8;
	localparam logic [7:0] HALF_D64 = 8'd32;
	localparam int         CLK_HZ   = 20000000;
	localparam logic [3:0] BITS     = 4'd8;
	typedef enum logic [2:0] {SSP_IDLE, SSP_SHIFT, SSP_START, SSP_RESTART,
		SSP_STOP, SSP_ACK} ssp_state_t;
endpackage

// ==== rtl/ssp_sync_if.sv ====
interface ssp_sync_if;
	logic [4:0] raw;
	logic [4:0] sync;
	modport sync_side (input raw, output sync);
	modport user (output raw, input sync);
endinterface

// ==== rtl/ssp_sync.sv ====
// two-flop synchroniser for pin inputs
module ssp_sync #(
	parameter int W = 5
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	ssp_sync_if.sync_side s
);
	logic [W-1:0] m_q;
	logic [W-1:0] m_d;
	logic [W-1:0] o_q;
	logic [W-1:0] o_d;
	always_comb
	begin
		m_d = s.raw;
		o_d = m_q;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			m_q <= '0;
			o_q <= '0;
		end
		else
		begin
			m_q <= m_d;
			o_q <= o_d;
		end
	end
	assign s.sync = o_q;
endmodule

// ==== verification/ssp_checker.sv ====
module ssp_checker
	import ssp_pkg::*;
(
	// system
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// wishbone
	input  wire logic                        cyc_i,
	input  wire logic                        stb_i,
	input  wire logic                        we_i,
	input  wire logic [ssp_pkg::WB_AW-1:0]   adr_i,
	input  wire logic [3:0]                  sel_i,
	input  wire logic [31:0]                 dat_i,
	input  wire logic [31:0]                 dat_o,
	input  wire logic                        ack_o,
	// pins and flags
	input  wire logic                        sck_oe_o,
	input  wire logic                        sdo_oe_o,
	input  wire logic                        pins_owned_o,
	input  wire logic                        ss_owned_o,
	input  wire logic                        port_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       req;
	logic       ctl_wr;
	logic       irq_wr;
	logic       mapped;
	logic [7:0] off;
	assign off = adr_i[9:2];
	assign req = cyc_i && stb_i && !ack_o;
	assign ctl_wr = req && we_i && sel_i[0] && off == ADDR_CTRL;
	assign irq_wr = cyc_i && stb_i && we_i && off == ADDR_IFLAG;
	assign mapped = off inside {ADDR_CTRL, ADDR_CTRL2, ADDR_STAT, ADDR_BUF, ADDR_ABAUD,
		ADDR_IFLAG, ADDR_TIMER};
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_latency: assert property (req |=> ack_o)
		else $error("ack missing one cycle after request");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_unmapped_zero: assert property (req && !we_i && !mapped |=> ack_o && dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_en_on: assert property (ctl_wr && dat_i[CTL_EN] |-> ##[1:3] pins_owned_o)
		else $error("pins not taken on enable");
	chk_en_off: assert property (ctl_wr && !dat_i[CTL_EN] |-> ##[1:3] !pins_owned_o)
		else $error("pins not returned on disable");
	chk_pins_idle: assert property (!pins_owned_o [*2] |-> !sck_oe_o && !sdo_oe_o)
		else $error("pin driven while port disabled");
	chk_select_use: assert property (ss_owned_o |-> pins_owned_o)
		else $error("select owned while port disabled");
	chk_irq_sticky: assert property ($fell(port_irq_o) |-> $past(irq_wr) || $past(irq_wr, 2))
		else $error("interrupt flag fell without clear");
endmodule

bind ssp_top ssp_checker ssp_checker_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .dat_o, .ack_o, .sck_oe_o, .sdo_oe_o, .pins_owned_o, .ss_owned_o, .port_irq_o);

// ==== verification/ssp_peer.sv ====
// spi slave on the far side, idle-low clock, edge bit clear
module ssp_peer
(
	input  wire logic       sck_i,
	input  wire logic       sdo_i,
	input  wire logic       load_i,
	input  wire logic [7:0] tx_i,
	output logic            sdi_o,
	output logic [7:0]      rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	int         cnt;
	initial sdi_o = 1'b1;
	always @(posedge load_i)
	begin
		sh = tx_i;
		cnt = 0;
		sdi_o = tx_i[7];
	end
	always @(posedge sck_i)
	begin
		rx_o = {rx_o[6:0], sdo_i};
		cnt++;
	end
	// after the last bit the line no longer holds data
	always @(negedge sck_i)
		sdi_o = (cnt < 8) ? sh[7-cnt] : ~sdi_o;
endmodule

// ==== verification/ssp_top_test.sv ====
module ssp_top_test;
	import ssp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [9:0]  adr_i = 10'h0;
	logic [3:0]  sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o;
	logic        pins_owned_o, ss_owned_o, port_irq_o, sdi, load = 1'b0;
	logic [7:0]  r, tx, pv, prx;
	logic [7:0]  q_exp[$];
	logic [3:0]  m;
	int          fail_count = 0;
	int          comparisons = 0;
	int          n;
	integer      seed;
	localparam logic [3:0] MODES [12] = '{M_SPI_D4, M_SPI_D16, M_SPI_D64, M_SPI_TMR, M_SPI_SS,
		M_SPI_NOSS, M_I2C_S7, M_I2C_S10, M_I2C_M, M_I2C_FW, M_I2C_S7I, M_I2C_S10I};
	always #25 clk_i = ~clk_i;
	ssp_top ssp_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .sck_i(1'b0), .sda_i(1'b1), .sdi_i(sdi), .ss_n_i(1'b1), .sck_o, .sck_oe_o,
		.sdo_o, .sdo_oe_o, .pins_owned_o, .ss_owned_o, .port_irq_o);
	ssp_peer ssp_peer_i (.sck_i(sck_o), .sdo_i(sdo_o), .load_i(load), .tx_i(pv),
		.sdi_o(sdi), .rx_o(prx));
	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {a, 2'b00};
		dat_i <= {24'h0, d};
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack_o !== 1'b1 && k < 20);
		r = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 20)
		begin
			fail_count++;
			print_verdict();
		end
	endtask
	initial
	begin
		seed = 32'h55b2d5ab;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, ADDR_CTRL, 0);
		chk(r, CTRL_RST);
		wb(0, ADDR_CTRL2, 0);
		chk(r, CTRL2_RST);
		wb(0, ADDR_STAT, 0);
		chk(r, STAT_RST);
		wb(1, ADDR_STAT, 8'hff);
		wb(0, ADDR_STAT, 0);
		chk(r, 8'hc0);
		wb(1, ADDR_STAT, 8'h00);
		wb(1, 8'h3f, 8'h5a);
		wb(0, 8'h3f, 0);
		chk(r, 8'h00);
		foreach (MODES[i])
		begin
			wb(1, ADDR_CTRL, {4'h2, MODES[i]});
			wb(0, ADDR_CTRL, 0);
			chk(r, {4'h2, MODES[i]});
			chk({7'h0, pins_owned_o}, 8'h1);
			chk({7'h0, ss_owned_o}, {7'h0, MODES[i] == M_SPI_SS});
			wb(1, ADDR_CTRL, {4'h0, MODES[i]});
			chk({7'h0, pins_owned_o}, 8'h0);
		end
		wb(1, ADDR_CTRL, {4'h2, M_SPI_D16});
		wb(1, ADDR_CTRL2, 8'h01);
		wb(0, ADDR_CTRL2, 0);
		chk(r, 8'h00);
		for (int t = 0; t < 4; t++)
		begin
			m = t[0] ? M_SPI_D64 : M_SPI_D16;
			wb(1, ADDR_CTRL, {4'h2, m});
			// later passes sample at end of bit time
			wb(1, ADDR_STAT, {t[1], 7'h00});
			tx = 8'($random(seed));
			pv <= 8'($random(seed));
			load <= 1'b1;
			@(posedge clk_i);
			q_exp.push_back(pv);
			load <= 1'b0;
			wb(1, ADDR_BUF, tx);
			wb(1, ADDR_BUF, ~tx);
			wb(0, ADDR_CTRL, 0);
			chk(r, {4'ha, m});
			n = 0;
			do
			begin
				wb(0, ADDR_STAT, 0);
				n++;
			end
			while (r[ST_BF] !== 1'b1 && n < 400);
			if (n >= 400)
			begin
				fail_count++;
				$display("Error %0t: buffer full never set", $time);
				print_verdict();
			end
			chk({7'h0, port_irq_o}, 8'h1);
			wb(0, ADDR_BUF, 0);
			chk(r, q_exp.pop_front());
			chk(prx, tx);
			wb(0, ADDR_STAT, 0);
			chk({7'h0, r[ST_BF]}, 8'h0);
			wb(1, ADDR_CTRL, {4'h2, m});
			wb(1, ADDR_IFLAG, 8'h00);
			chk({7'h0, port_irq_o}, 8'h0);
		end
		print_verdict();
	end
endmodule
